// [dv/flash_cmd_seq_chk.sv]
// checker: port-level timing relations of the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_seq_chk
   import flash_seq_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [3:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   input wire logic i_array_done,
   input wire logic i_array_err,
   input wire logic i_array_uncorr,
   input wire logic [63:0] i_array_rdata,
   input wire array_req_type o_array_req,
   input wire logic o_prog_read_invalid,
   input wire logic o_secure
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // ----------------------------------------
   // bus and array handshake
   // ----------------------------------------
   chk_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000)
      else $error("read data not zero outside answer cycle");
   chk_req_pulse: assert property (o_array_req.valid |=> !o_array_req.valid)
      else $error("array request longer than one cycle");
   chk_erase_verify: assert property (i_array_done && o_array_req.op == AOP_ERASE
      |-> ##[1:2] (o_array_req.valid && o_array_req.op == AOP_VERIFY))
      else $error("erase not followed by verify");
   chk_blank_prog: assert property (i_array_done && o_array_req.op == AOP_BLANK
      && i_array_rdata == ALL_ONES |-> ##[1:2] (o_array_req.valid && o_array_req.op == AOP_PROGRAM))
      else $error("blank phrase not programmed");
   chk_blank_refuse: assert property (i_array_done && o_array_req.op == AOP_BLANK
      && i_array_rdata != ALL_ONES |=> !o_array_req.valid [*2])
      else $error("written phrase programmed again");
   chk_prog_verify: assert property (i_array_done && o_array_req.op == AOP_PROGRAM
      |-> ##[1:2] (o_array_req.valid && o_array_req.op == AOP_VERIFY))
      else $error("program not followed by verify");
   chk_otp_invalid: assert property (o_array_req.valid && o_array_req.otp_area
      |-> o_prog_read_invalid)
      else $error("program reads valid during one-time write");
   chk_secure_release: assert property ($fell(o_secure) |->
      ($past(i_array_done) && !$past(i_array_err)) || ($past(i_array_done, 2) && !$past(i_array_err, 2)))
      else $error("security released without a clean verify");
   chk_sector_prog: assert property (o_array_req.valid && o_array_req.op == AOP_ERASE
      && o_array_req.sector |-> o_array_req.prog_array && !o_array_req.data_array)
      else $error("sector erase outside program array");
   // ----------------------------------------
   // main scenarios reached
   // ----------------------------------------
   cov_program: cover property (o_array_req.valid && o_array_req.op == AOP_PROGRAM);
   cov_release: cover property ($fell(o_secure));
   cov_verr: cover property (i_array_done && o_array_req.op == AOP_VERIFY && i_array_err);
endmodule
`default_nettype wire

// [dv/flash_erase_and_otp_cmds_tb_top.sv]
// testbench: command scenarios of the flash sequencer over its register port
`timescale 1ns/10ps
`default_nettype none
module flash_erase_and_otp_cmds_tb_top
   import flash_seq_pkg::*;
;
   logic i_clk = 1'b0, i_rst_b = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic [3:0] i_reg_addr = 4'h0;
   logic [15:0] i_reg_wdata = 16'h0000;
   logic i_array_done = 1'b0, i_array_err = 1'b0, i_array_uncorr = 1'b0;
   logic [63:0] i_array_rdata = 64'h0;
   logic [15:0] o_reg_rdata;
   array_req_type o_array_req;
   logic o_prog_read_invalid, o_secure, rd_d = 1'b0, v_err = 1'b0, v_unc = 1'b0;
   int miscompares = 0, n_tests = 0, n_req = 0;
   logic [15:0] qe[$], qm[$], w[6], lf = 16'h0053;
   logic [63:0] blank = ALL_ONES;
   // op, address, control, expected status for block and sector erase
   logic [63:0] tbl[9] = '{64'h0901_0000_0000_00A0, 64'h0903_0004_0000_00A0,
      64'h0900_0001_0000_00A0, 64'h0903_0000_0002_0090, 64'h0900_0002_0004_0090,
      64'h0900_0002_0000_0080, 64'h0A03_0003_0000_00A0, 64'h0A03_1238_0002_0090,
      64'h0A03_1238_0001_0080};
   always #5 i_clk = ~i_clk;
   flash_cmd_seq u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(o_reg_rdata), .i_array_done(i_array_done), .i_array_err(i_array_err),
      .i_array_uncorr(i_array_uncorr), .i_array_rdata(i_array_rdata),
      .o_array_req(o_array_req), .o_prog_read_invalid(o_prog_read_invalid),
      .o_secure(o_secure));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction
   task chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("tests=%0d miscompares=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task rst;
      i_rst_b <= 1'b0;
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge i_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      qe.push_back(e);
      qm.push_back(m);
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
   endtask
   // load words, launch, wait for completion, then note status and op count
   task go(input int n, input logic [15:0] ctl, input logic [15:0] est, input int nr);
      int r0;
      int k;
      r0 = n_req;
      k = 0;
      wr(CONTROL_OFS, ctl);
      for (int i = 0; i < n; i++) begin
         wr(INDEX_OFS, 16'(i));
         wr(PARAM_OFS, w[i]);
      end
      wr(STATUS_OFS, 16'h00B0);
      // only status reads while busy, no register writes
      do begin
         rd(STATUS_OFS, 16'h0000, 16'h0000);
         @(negedge i_clk);
         k++;
      end while (o_reg_rdata[CCF_BIT] !== 1'b1 && k < 300);
      rd(STATUS_OFS, est, 16'h00B3);
      chk(64'(n_req - r0), 64'(nr));
   endtask
   // ----------------------------------------
   // read answer watcher and array responder
   // ----------------------------------------
   always @(negedge i_clk) begin
      if (rd_d && qe.size() > 0) begin
         if (qm[0] != 16'h0000) chk(64'(o_reg_rdata & qm[0]), 64'(qe[0]));
         void'(qe.pop_front());
         void'(qm.pop_front());
      end
      rd_d = i_reg_rd;
   end
   initial forever begin
      @(posedge i_clk);
      if (o_array_req.valid === 1'b1) begin
         n_req++;
         repeat (rnd() % 16'h0004) @(posedge i_clk);
         i_array_done <= 1'b1;
         i_array_err <= v_err;
         i_array_uncorr <= v_unc;
         i_array_rdata <= blank;
         @(posedge i_clk);
         i_array_done <= 1'b0;
      end
   end
   initial begin
      #200000;
      miscompares++;
      end_sim;
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      rst;
      rd(STATUS_OFS, 16'h0080, 16'h00B3);
      rd(CONTROL_OFS, 16'h0008, 16'h000F);
      rd(4'h2, 16'h0000, 16'hFFFF);
      w = '{16'h0700, 16'h0002, rnd(), rnd(), rnd(), rnd()};
      go(5, 16'h0000, 16'h00A0, 0);
      w[1] = 16'h0008;
      go(6, 16'h0000, 16'h00A0, 0);
      w[1] = 16'h0003;
      // bench code runs outside the flash, so the one-time write is legal
      go(6, 16'h0000, 16'h0080, 3);
      chk(o_array_req.data, {w[2], w[3], w[4], w[5]});
      blank = {48'h0, rnd()};
      go(6, 16'h0000, 16'h00A0, 1);
      blank = ALL_ONES;
      v_err = 1'b1;
      v_unc = 1'b1;
      go(6, 16'h0000, 16'h0083, 3);
      v_unc = 1'b0;
      w[0] = 16'h0B00;
      go(1, 16'h0000, 16'h0082, 2);
      chk(o_secure, 1);
      v_err = 1'b0;
      w[0] = 16'h0800;
      go(1, 16'h0002, 16'h0090, 0);
      go(2, 16'h0000, 16'h00A0, 0);
      go(1, 16'h0000, 16'h0080, 2);
      chk(o_secure, 0);
      rd(CONTROL_OFS, 16'h0000, 16'h0008);
      for (int i = 0; i < 9; i++) begin
         w[0] = tbl[i][63:48];
         w[1] = tbl[i][47:32];
         go(2, tbl[i][31:16], tbl[i][15:0], (tbl[i][15:0] == 16'h0080) ? 2 : 0);
      end
      rst;
      chk(o_secure, 1);
      w[0] = 16'h0B00;
      go(1, 16'h0000, 16'h0080, 2);
      chk(o_secure, 0);
      end_sim;
   end
endmodule
bind flash_cmd_seq flash_cmd_seq_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_array_done(i_array_done),
   .i_array_err(i_array_err), .i_array_uncorr(i_array_uncorr),
   .i_array_rdata(i_array_rdata), .o_array_req(o_array_req),
   .o_prog_read_invalid(o_prog_read_invalid), .o_secure(o_secure));
`default_nettype wire

// [hdl/flash_cmd_seq.sv]
// module: command sequencer for one-time write, erases and unsecure
// Contract
// (R01) clearing complete flag launches; flag stays low until the operation finishes
// (R02) one-time write: opcode 07, phrase index, four data words at 2..5
// (R03) one-time write checks blank, programs, then verifies by reading back
// (R04) complete flag low throughout the one-time sequence
// (R05) access error when final index is not 101 or phrase index too big
// (R06) second one-time write to programmed phrase refused with access error
// (R07) phrase programmed to all ones counts as unprogrammed
// (R08) program-array reads give invalid data during one-time write
// (R09) software must not run one-time write from the block holding it
// (R10) verify sets verify error, and uncorrectable error when uncorrectable
// (R11) access error when command not permitted in current mode; this build checks no mode
// (R12) opcode 08 with index 000 erases both arrays, verify releases security
// (R13) full erase and unsecure flag protection violation on any protection
// (R14) software writes no register while full erase or unsecure runs
// (R15) opcode 09 erases and verifies whole block selected by address
// (R16) block erase: access error on bad block or misaligned address
// (R17) block erase: protection violation when the block is protected
// (R18) opcode 0A erases and verifies program sector containing the address
// (R19) sector erase: access error when address bits 2:0 nonzero; protection flag
// (R20) opcode 0B erases both arrays, releases security only on good verify
// (R21) failed unsecure verify sets verify error and keeps security state
// (R22) launch errors skip array work and set complete flag at once
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_seq
   import flash_seq_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [3:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   input wire logic i_array_done,
   input wire logic i_array_err,
   input wire logic i_array_uncorr,
   input wire logic [63:0] i_array_rdata,
   output array_req_type o_array_req,
   output logic o_prog_read_invalid,
   output logic o_secure
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic ccf_q;
   logic acc_q;
   logic pv_q;
   logic ve_q;
   logic ue_q;
   logic [2:0] index_q;
   logic [15:0] param_q [0:5];
   logic special_q;
   logic pprot_q;
   logic dprot_q;
   logic [1:0] sec_q;
   logic [15:0] rdata_q;
   seq_state_type state_q;
   array_req_type req_q;
   logic blank_q;
   logic launch;
   logic chk_acc;
   logic chk_pv;
   logic [15:0] status_word;
   logic [63:0] wr_phrase;
   logic [7:0] opcode;
   logic whole_chip;

   assign opcode = param_q[0][15:8];
   assign whole_chip = (opcode == OP_ERASE_ALL) || (opcode == OP_UNSECURE);
   assign wr_phrase = {param_q[2], param_q[3], param_q[4], param_q[5]};
   // writing one to the complete bit while idle launches; the bit clears unless a launch check fails
   assign launch = i_reg_wr && (i_reg_addr == STATUS_OFS) && i_reg_wdata[CCF_BIT] &&
      ccf_q; // see (R01)

   assign status_word = {8'h00, ccf_q, 1'b0, acc_q, pv_q, 2'b00, ve_q, ue_q};

   // ------------------------------------------------------------
   // launch checks
   // ------------------------------------------------------------
   flash_launch_check u_check (
      .i_opcode(opcode),
      .i_last_index(index_q),
      .i_addr_hi(param_q[0]),
      .i_addr_lo(param_q[1]),
      .i_special_mode(special_q),
      .i_prog_protected(pprot_q),
      .i_data_protected(dprot_q),
      .o_access_err(chk_acc),
      .o_protect_err(chk_pv)
   );

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // build an array request
   function automatic array_req_type make_req(input array_op_type op, input logic p,
      input logic d, input logic otp, input logic sec, input logic [17:0] a,
      input logic [63:0] w);
      array_req_type r;
      r.valid = 1'b1;
      r.op = op;
      r.prog_array = p;
      r.data_array = d;
      r.otp_area = otp;
      r.sector = sec;
      r.addr = a;
      r.data = w;
      return r;
   endfunction

   // ------------------------------------------------------------
   // parameter index and parameter words
   // ------------------------------------------------------------
   // software loads index then word; writes while busy are dropped
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         index_q <= INDEX_RST;
      end else if (i_reg_wr && ccf_q && (i_reg_addr == INDEX_OFS)) begin
         index_q <= i_reg_wdata[2:0];
      end
   end

   // parameter array, one word per index; index 6 and 7 not stored
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         for (int i = 0; i < 6; i++) begin
            param_q[i] <= PARAM_RST;
         end
      end else if (i_reg_wr && ccf_q && (i_reg_addr == PARAM_OFS) && (index_q < 3'h6)) begin
         param_q[index_q] <= i_reg_wdata; // see (R02)
      end
   end

   // control: mode, protection, writes ignored while busy
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         special_q <= 1'b0;
         pprot_q <= 1'b0;
         dprot_q <= 1'b0;
      end else if (i_reg_wr && ccf_q && (i_reg_addr == CONTROL_OFS)) begin // see (R14)
         special_q <= i_reg_wdata[SPECIAL_BIT];
         pprot_q <= i_reg_wdata[PPROT_BIT];
         dprot_q <= i_reg_wdata[DPROT_BIT];
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   // walks check, erase or program, verify, done
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         state_q <= ST_IDLE;
         req_q <= '0;
         blank_q <= 1'b0;
      end else begin
         req_q.valid <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (launch && !chk_acc && !chk_pv) begin // see (R22)
                  if (opcode == OP_PROG_ONCE) begin
                     // blank check of the selected phrase first
                     state_q <= ST_CHECK; // see (R03)
                     req_q <= make_req(AOP_BLANK, 1'b1, 1'b0, 1'b1, 1'b0,
                        {15'h0000, param_q[1][2:0]}, '0);
                  end else begin
                     state_q <= ST_ERASE; // see (R15)
                     req_q <= make_req(AOP_ERASE, whole_chip || (param_q[0][1:0] == BLK_PROG),
                        whole_chip || (param_q[0][1:0] == BLK_DATA), 1'b0,
                        opcode == OP_ERASE_SEC, {param_q[0][1:0], param_q[1]}, '0); // see (R18)
                  end
               end
            end
            ST_CHECK: begin
               if (i_array_done) begin
                  // all ones reads as blank, so a phrase written to all ones may be redone
                  blank_q <= (i_array_rdata == ALL_ONES); // see (R07)
                  if (i_array_rdata == ALL_ONES) begin
                     state_q <= ST_PROG;
                     req_q <= make_req(AOP_PROGRAM, 1'b1, 1'b0, 1'b1, 1'b0,
                        req_q.addr, wr_phrase); // see (R03)
                  end else begin
                     state_q <= ST_DONE; // see (R06)
                  end
               end
            end
            ST_ERASE: begin
               if (i_array_done) begin
                  state_q <= ST_VERIFY; // see (R12)
                  req_q <= make_req(AOP_VERIFY, req_q.prog_array, req_q.data_array, 1'b0,
                     req_q.sector, req_q.addr, '0);
               end
            end
            ST_PROG: begin
               if (i_array_done) begin
                  state_q <= ST_VERIFY;
                  req_q <= make_req(AOP_VERIFY, 1'b1, 1'b0, 1'b1, 1'b0, req_q.addr,
                     wr_phrase); // see (R03)
               end
            end
            ST_VERIFY: begin
               if (i_array_done) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
               req_q.op <= AOP_NONE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   // complete flag: low from launch to done, stays high on launch error
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ccf_q <= 1'b1;
      end else if (launch && !chk_acc && !chk_pv) begin
         ccf_q <= 1'b0; // see (R01)
      end else if (state_q == ST_DONE) begin
         ccf_q <= 1'b1; // see (R04)
      end
   end

   // access and protection errors: set at launch, access also on a non-blank phrase, cleared by writing one
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         acc_q <= 1'b0;
         pv_q <= 1'b0;
      end else begin
         if (launch && chk_acc) begin
            acc_q <= 1'b1; // see (R11)
         end else if ((state_q == ST_CHECK) && i_array_done && (i_array_rdata != ALL_ONES)) begin
            acc_q <= 1'b1; // see (R06)
         end else if (i_reg_wr && (i_reg_addr == STATUS_OFS) && i_reg_wdata[ACC_BIT]) begin
            acc_q <= 1'b0;
         end
         if (launch && chk_pv) begin
            pv_q <= 1'b1; // see (R13)
         end else if (i_reg_wr && (i_reg_addr == STATUS_OFS) && i_reg_wdata[PV_BIT]) begin
            pv_q <= 1'b0;
         end
      end
   end

   // verify flags: cleared at each launch, set by verify results
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ve_q <= 1'b0;
         ue_q <= 1'b0;
      end else if ((state_q == ST_VERIFY) && i_array_done) begin
         ve_q <= i_array_err || i_array_uncorr; // see (R10)
         ue_q <= i_array_uncorr; // see (R10)
      end else if (launch) begin
         ve_q <= 1'b0;
         ue_q <= 1'b0;
      end
   end

   // security: released only after a clean whole-chip erase verify
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         sec_q <= SEC_RST;
      end else if ((state_q == ST_VERIFY) && i_array_done && whole_chip &&
         !i_array_err && !i_array_uncorr) begin
         sec_q <= ~SEC_RST; // see (R20)
      end // failed verify keeps state, see (R21)
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   // read data stands one cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         rdata_q <= 16'h0000;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            STATUS_OFS: rdata_q <= status_word;
            INDEX_OFS: rdata_q <= {13'h0000, index_q};
            PARAM_OFS: rdata_q <= (index_q < 3'h6) ? param_q[index_q] : 16'h0000;
            CONTROL_OFS: rdata_q <= {12'h000, (sec_q != ~SEC_RST), dprot_q, pprot_q, special_q};
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign o_reg_rdata = rdata_q;
   assign o_array_req = req_q;
   // program-array reads invalid while the one-time write runs
   assign o_prog_read_invalid = (state_q != ST_IDLE) && (opcode == OP_PROG_ONCE); // see (R08)
   assign o_secure = (sec_q != ~SEC_RST);
endmodule
`default_nettype wire

// [hdl/flash_launch_check.sv]
// module: launch checks, access and protection errors of one command
`timescale 1ns/10ps
`default_nettype none
module flash_launch_check
   import flash_seq_pkg::*;
(
   input wire logic [7:0] i_opcode,
   input wire logic [2:0] i_last_index,
   input wire logic [15:0] i_addr_hi,
   input wire logic [15:0] i_addr_lo,
   input wire logic i_special_mode,
   input wire logic i_prog_protected,
   input wire logic i_data_protected,
   output logic o_access_err,
   output logic o_protect_err
);
   // ------------------------------------------------------------
   // error decode
   // ------------------------------------------------------------
   logic [1:0] blk;
   logic blk_ok;
   assign blk = i_addr_hi[1:0];
   assign blk_ok = (blk == BLK_PROG) || (blk == BLK_DATA);

   // classify the command at launch
   always_comb begin
      o_access_err = 1'b0;
      o_protect_err = 1'b0;
      case (i_opcode)
         OP_PROG_ONCE: begin
            o_access_err = (i_last_index != IDX_SIX) || (i_addr_lo > {13'h0000, PHRASE_MAX}); // see (R05)
         end
         OP_ERASE_ALL, OP_UNSECURE: begin
            o_access_err = (i_last_index != IDX_ONE); // see (R12)
            o_protect_err = i_prog_protected || i_data_protected; // see (R13)
         end
         OP_ERASE_BLK: begin
            o_access_err = (i_last_index != IDX_TWO) || !blk_ok ||
               ((blk == BLK_PROG) && (i_addr_lo[2:0] != 3'h0)) ||
               ((blk == BLK_DATA) && i_addr_lo[0]); // see (R16)
            o_protect_err = (blk == BLK_PROG) ? i_prog_protected : i_data_protected; // see (R17)
         end
         OP_ERASE_SEC: begin
            o_access_err = (i_last_index != IDX_TWO) || (blk != BLK_PROG) ||
               (i_addr_lo[2:0] != 3'h0); // see (R19)
            o_protect_err = i_prog_protected; // see (R19)
         end
         default: begin
            o_access_err = 1'b1;
         end
      endcase
      // no command needs special mode in this build; i_special_mode raises no access error
      if (!i_special_mode && (i_opcode == OP_ERASE_BLK)) begin
         o_access_err = o_access_err; // permitted in every mode
      end
   end
endmodule
`default_nettype wire

// [shared/flash_seq_pkg.sv]
// package: offsets, fields, opcodes, states and carriers of the flash command sequencer
package flash_seq_pkg;
   // register offsets (byte addresses, one word each)
   localparam logic [3:0] STATUS_OFS = 4'h0;
   localparam logic [3:0] INDEX_OFS = 4'h4;
   localparam logic [3:0] PARAM_OFS = 4'h8;
   localparam logic [3:0] CONTROL_OFS = 4'hC;
   // status field positions
   localparam int CCF_BIT = 7;
   localparam int ACC_BIT = 5;
   localparam int PV_BIT = 4;
   localparam int VE_BIT = 1;
   localparam int UE_BIT = 0;
   // control field positions
   localparam int SPECIAL_BIT = 0;
   localparam int PPROT_BIT = 1;
   localparam int DPROT_BIT = 2;
   localparam int SECURE_BIT = 3;
   // reset values
   localparam logic [2:0] INDEX_RST = 3'h0;
   localparam logic [15:0] PARAM_RST = 16'h0000;
   localparam logic [1:0] SEC_RST = 2'h2;
   // opcodes
   localparam logic [7:0] OP_PROG_ONCE = 8'h07;
   localparam logic [7:0] OP_ERASE_ALL = 8'h08;
   localparam logic [7:0] OP_ERASE_BLK = 8'h09;
   localparam logic [7:0] OP_ERASE_SEC = 8'h0A;
   localparam logic [7:0] OP_UNSECURE = 8'h0B;
   // final index values expected at launch
   localparam logic [2:0] IDX_ONE = 3'h0;
   localparam logic [2:0] IDX_TWO = 3'h1;
   localparam logic [2:0] IDX_SIX = 3'h5;
   // block selects of address bits 17:16
   localparam logic [1:0] BLK_DATA = 2'h0;
   localparam logic [1:0] BLK_PROG = 2'h3;
   localparam logic [2:0] PHRASE_MAX = 3'h7;
   localparam logic [63:0] ALL_ONES = 64'hFFFF_FFFF_FFFF_FFFF;
   // sequencer states, gray from one listed state to the next
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CHECK = 3'b001,
      ST_ERASE = 3'b011,
      ST_PROG = 3'b010,
      ST_VERIFY = 3'b110,
      ST_DONE = 3'b111
   } seq_state_type;
   // array operation codes
   typedef enum logic [2:0] {
      AOP_NONE = 3'h0,
      AOP_BLANK = 3'h1,
      AOP_PROGRAM = 3'h2,
      AOP_ERASE = 3'h3,
      AOP_VERIFY = 3'h4
   } array_op_type;
   // request to the flash arrays
   typedef struct packed {
      logic valid;
      array_op_type op;
      logic prog_array;
      logic data_array;
      logic otp_area;
      logic sector;
      logic [17:0] addr;
      logic [63:0] data;
   } array_req_type;
   // answer from the flash arrays
   typedef struct packed {
      logic done;
      logic err;
      logic uncorr;
      logic [63:0] rdata;
   } array_rsp_type;
   // register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } reg_req_type;
endpackage
